/* common/rfs_map.svh */
// register offsets, reset values, action codes and timing of the fault block
`ifndef RFS_MAP_SVH
`define RFS_MAP_SVH

// command codes
`define RFS_OFS_OPERATION   8'h01
`define RFS_OFS_ONOFF_CFG   8'h02
`define RFS_OFS_CLEAR       8'h03
`define RFS_OFS_SCALE       8'h29
`define RFS_OFS_UV_LIM      8'h44
`define RFS_OFS_UV_ACT      8'h45
`define RFS_OFS_OC_LIM      8'h46
`define RFS_OFS_OC_ACT      8'h47
`define RFS_OFS_OC_WARN     8'h4a
`define RFS_OFS_OT_LIM      8'h4f
`define RFS_OFS_OT_ACT      8'h50
`define RFS_OFS_OT_WARN     8'h51
`define RFS_OFS_VIN_OV_LIM  8'h55
`define RFS_OFS_VIN_OV_ACT  8'h56
`define RFS_OFS_VIN_UV_LIM  8'h58
`define RFS_OFS_PG_ON       8'h5e
`define RFS_OFS_PG_OFF      8'h5f
`define RFS_OFS_TON_DLY     8'h60
`define RFS_OFS_TURN_ON_RISE_TIME    8'h61
`define RFS_OFS_TURN_ON_TIMEOUT     8'h62
`define RFS_OFS_TURN_ON_TIMEOUT_ACT 8'h63
`define RFS_OFS_TOFF_DLY    8'h64
`define RFS_OFS_TURN_OFF_FALL_TIME   8'h65
`define RFS_OFS_STATUS      8'h78

// response codes
`define RFS_ACT_IGNORE      8'h00
`define RFS_ACT_SHUTDOWN    8'h80
`define RFS_ACT_INHIBIT     8'hc0

// reset values, in each register's own step
`define RFS_RST_UV_LIM      16'h0065
`define RFS_RST_OC_LIM      16'h0012
`define RFS_RST_OC_WARN     16'h000f
`define RFS_RST_OT_LIM      16'h0091
`define RFS_RST_OT_WARN     16'h007d
`define RFS_RST_VIN_OV_LIM  16'h0060
`define RFS_RST_VIN_UV_LIM  16'h0001
`define RFS_RST_PG_ON       16'h002d
`define RFS_RST_PG_OFF      16'h002a
`define RFS_RST_TON_DLY     16'h0000
`define RFS_RST_TURN_ON_RISE_TIME    16'h0002
`define RFS_RST_TURN_ON_TIMEOUT     16'h0000
`define RFS_RST_TOFF_DLY    16'h0000
`define RFS_RST_TURN_OFF_FALL_TIME   16'h0001
`define RFS_RST_SCALE       16'h0008
`define RFS_RST_OPERATION   16'h0000
`define RFS_RST_ONOFF_CFG   16'h0004

// status byte bits
`define RFS_STB_OFF         6
`define RFS_STB_OC          4
`define RFS_STB_VIN_UV      3
`define RFS_STB_TEMP        2
`define RFS_STB_CML         1
`define RFS_STB_OTHER       0

// timing: one step of every timer is one millisecond
`define RFS_CLK_KHZ         25000
`define RFS_STEP_MS         1
`define RFS_NSLOT           22

`endif

/* common/rfs_pkg.sv */
// types of the regulator fault and sequencing register block
`include "rfs_map.svh"
package rfs_pkg;
  typedef enum logic [2:0] {
    ST_OFF, ST_DLY_ON, ST_RISE, ST_ON, ST_DLY_OFF, ST_FALL
  } rfs_seq_t;

  typedef enum logic [4:0] {
    SL_UV_LIM, SL_UV_ACT, SL_OC_LIM, SL_OC_ACT, SL_OC_WARN, SL_OT_LIM,
    SL_OT_ACT, SL_OT_WARN, SL_VIN_OV_LIM, SL_VIN_OV_ACT, SL_VIN_UV_LIM,
    SL_PG_ON, SL_PG_OFF, SL_TON_DLY, SL_TURN_ON_RISE_TIME, SL_TURN_ON_TIMEOUT,
    SL_TURN_ON_TIMEOUT_ACT, SL_TOFF_DLY, SL_TURN_OFF_FALL_TIME, SL_OPERATION, SL_ONOFF,
    SL_SCALE, SL_STATUS, SL_NONE
  } rfs_slot_t;

  typedef struct packed {
    logic [`RFS_NSLOT-1:0][15:0] cfg;
    rfs_seq_t                    seq;
    logic [1:0]                  en_sync;
    logic [15:0]                 tick;
    logic [6:0]                  ms;
    logic [6:0]                  ton_ms;
    logic                        reached;
    logic                        latch_off;
    logic                        pgood;
    logic [7:0]                  status;
    logic [15:0]                 rsp_data;
    logic                        rsp_valid;
  } rfs_state_t;
endpackage : rfs_pkg

/* hw/rfs_regs.sv */
// fault limits, responses, on/off sequencing and summary status of the regulator
`timescale 1ns/1ps
`default_nettype none
`include "rfs_map.svh"

// Function
// (RULE1) undervoltage limit held, fault below it
// (RULE2) undervoltage response ignore or shutdown, ignore
// (RULE3) overcurrent limit held, fault above it
// (RULE4) overcurrent response selects regulator action
// (RULE5) overtemperature limit held, fault at it
// (RULE6) overtemperature response ignore/shutdown/inhibit, inhibit
// (RULE7) overtemperature warning limit, warning at it
// (RULE8) input overvoltage limit, fault above it
// (RULE9) input overvoltage response, default shutdown
// (RULE10) input undervoltage warning limit, compared
// (RULE11) power good asserts at on threshold
// (RULE12) power good negates at off threshold
// (RULE13) turn-on delay before output rises
// (RULE14) rise time into regulation band
// (RULE15) turn-on timeout fault, zero disables
// (RULE16) timeout response ignore or shutdown
// (RULE17) turn-off delay keeps energy flowing
// (RULE18) fall time after turn-off delay
// (RULE19) status upper nibble: busy, off, ov, oc; the busy and ov bits are held at zero
// (RULE20) status lower nibble: vin, temp, cml, other
// (RULE21) start/stop from pin and command per config
// (RULE22) output thresholds divided by loop scale
// (RULE23) faults latched, response applied next cycle
// (RULE24) host writes full-width values before enabling
module rfs_regs #(
  parameter int unsigned CYC_PER_STEP = `RFS_STEP_MS * `RFS_CLK_KHZ
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // decoded management command port
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  output var  logic        rsp_valid,
  output var  logic [15:0] rsp_data,
  // enable pin, asynchronous
  input  wire logic        en_pin,
  // sensed values from converter logic
  input  wire logic [15:0] vout_code,
  input  wire logic [15:0] iout_code,
  input  wire logic [15:0] temp_code,
  input  wire logic [15:0] vin_code,
  // power stage control
  output var  logic        deliver_on,
  output var  logic        ramp_up,
  output var  logic        ramp_down,
  output var  logic        power_good,
  output var  logic [7:0]  status_byte
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic rfs_pkg::rfs_state_t rst_val();
    rfs_pkg::rfs_state_t v;
    v = '0;
    v.cfg[rfs_pkg::SL_UV_LIM]      = `RFS_RST_UV_LIM;
    v.cfg[rfs_pkg::SL_UV_ACT]      = {8'h00, `RFS_ACT_IGNORE};
    v.cfg[rfs_pkg::SL_OC_LIM]      = `RFS_RST_OC_LIM;
    v.cfg[rfs_pkg::SL_OC_ACT]      = {8'h00, `RFS_ACT_SHUTDOWN};
    v.cfg[rfs_pkg::SL_OC_WARN]     = `RFS_RST_OC_WARN;
    v.cfg[rfs_pkg::SL_OT_LIM]      = `RFS_RST_OT_LIM;
    v.cfg[rfs_pkg::SL_OT_ACT]      = {8'h00, `RFS_ACT_INHIBIT};
    v.cfg[rfs_pkg::SL_OT_WARN]     = `RFS_RST_OT_WARN;
    v.cfg[rfs_pkg::SL_VIN_OV_LIM]  = `RFS_RST_VIN_OV_LIM;
    v.cfg[rfs_pkg::SL_VIN_OV_ACT]  = {8'h00, `RFS_ACT_SHUTDOWN};
    v.cfg[rfs_pkg::SL_VIN_UV_LIM]  = `RFS_RST_VIN_UV_LIM;
    v.cfg[rfs_pkg::SL_PG_ON]       = `RFS_RST_PG_ON;
    v.cfg[rfs_pkg::SL_PG_OFF]      = `RFS_RST_PG_OFF;
    v.cfg[rfs_pkg::SL_TON_DLY]     = `RFS_RST_TON_DLY;
    v.cfg[rfs_pkg::SL_TURN_ON_RISE_TIME]    = `RFS_RST_TURN_ON_RISE_TIME;
    v.cfg[rfs_pkg::SL_TURN_ON_TIMEOUT]     = `RFS_RST_TURN_ON_TIMEOUT;
    v.cfg[rfs_pkg::SL_TURN_ON_TIMEOUT_ACT] = {8'h00, `RFS_ACT_IGNORE};
    v.cfg[rfs_pkg::SL_TOFF_DLY]    = `RFS_RST_TOFF_DLY;
    v.cfg[rfs_pkg::SL_TURN_OFF_FALL_TIME]   = `RFS_RST_TURN_OFF_FALL_TIME;
    v.cfg[rfs_pkg::SL_OPERATION]   = `RFS_RST_OPERATION;
    v.cfg[rfs_pkg::SL_ONOFF]       = `RFS_RST_ONOFF_CFG;
    v.cfg[rfs_pkg::SL_SCALE]       = `RFS_RST_SCALE;
    v.seq                          = rfs_pkg::ST_OFF;
    v.status                       = 8'h40;
    return v;
  endfunction : rst_val

  function automatic rfs_pkg::rfs_slot_t slot_of(input logic [7:0] c);
    unique case (c)
      `RFS_OFS_UV_LIM:      slot_of = rfs_pkg::SL_UV_LIM;
      `RFS_OFS_UV_ACT:      slot_of = rfs_pkg::SL_UV_ACT;
      `RFS_OFS_OC_LIM:      slot_of = rfs_pkg::SL_OC_LIM;
      `RFS_OFS_OC_ACT:      slot_of = rfs_pkg::SL_OC_ACT;
      `RFS_OFS_OC_WARN:     slot_of = rfs_pkg::SL_OC_WARN;
      `RFS_OFS_OT_LIM:      slot_of = rfs_pkg::SL_OT_LIM;
      `RFS_OFS_OT_ACT:      slot_of = rfs_pkg::SL_OT_ACT;
      `RFS_OFS_OT_WARN:     slot_of = rfs_pkg::SL_OT_WARN;
      `RFS_OFS_VIN_OV_LIM:  slot_of = rfs_pkg::SL_VIN_OV_LIM;
      `RFS_OFS_VIN_OV_ACT:  slot_of = rfs_pkg::SL_VIN_OV_ACT;
      `RFS_OFS_VIN_UV_LIM:  slot_of = rfs_pkg::SL_VIN_UV_LIM;
      `RFS_OFS_PG_ON:       slot_of = rfs_pkg::SL_PG_ON;
      `RFS_OFS_PG_OFF:      slot_of = rfs_pkg::SL_PG_OFF;
      `RFS_OFS_TON_DLY:     slot_of = rfs_pkg::SL_TON_DLY;
      `RFS_OFS_TURN_ON_RISE_TIME:    slot_of = rfs_pkg::SL_TURN_ON_RISE_TIME;
      `RFS_OFS_TURN_ON_TIMEOUT:     slot_of = rfs_pkg::SL_TURN_ON_TIMEOUT;
      `RFS_OFS_TURN_ON_TIMEOUT_ACT: slot_of = rfs_pkg::SL_TURN_ON_TIMEOUT_ACT;
      `RFS_OFS_TOFF_DLY:    slot_of = rfs_pkg::SL_TOFF_DLY;
      `RFS_OFS_TURN_OFF_FALL_TIME:   slot_of = rfs_pkg::SL_TURN_OFF_FALL_TIME;
      `RFS_OFS_OPERATION:   slot_of = rfs_pkg::SL_OPERATION;
      `RFS_OFS_ONOFF_CFG:   slot_of = rfs_pkg::SL_ONOFF;
      `RFS_OFS_SCALE:       slot_of = rfs_pkg::SL_SCALE;
      `RFS_OFS_STATUS:      slot_of = rfs_pkg::SL_STATUS;
      default:              slot_of = rfs_pkg::SL_NONE;
    endcase
  endfunction : slot_of

  // byte-wide commands keep their upper byte at zero
  function automatic logic is_byte(input rfs_pkg::rfs_slot_t sl);
    return sl inside {rfs_pkg::SL_UV_ACT, rfs_pkg::SL_OC_ACT,
                      rfs_pkg::SL_OT_ACT, rfs_pkg::SL_VIN_OV_ACT,
                      rfs_pkg::SL_TURN_ON_TIMEOUT_ACT, rfs_pkg::SL_OPERATION,
                      rfs_pkg::SL_ONOFF};
  endfunction : is_byte

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  rfs_pkg::rfs_state_t s_r;
  rfs_pkg::rfs_state_t s_nxt;
  rfs_pkg::rfs_slot_t  slot;
  logic [19:0]         vprod;
  logic [15:0]         vsc;
  logic                start;
  logic                ms_tick;
  logic                clr;
  logic                cml;
  logic                uv_cond;
  logic                oc_cond;
  logic                ot_cond;
  logic                otw_cond;
  logic                vov_cond;
  logic                vuv_cond;
  logic                tmo_cond;
  logic                sd_any;
  logic                inhibit;

  assign slot = slot_of(cmd_code);
  // output-referred limits are compared against sense times scale/8
  assign vprod = vout_code * s_r.cfg[rfs_pkg::SL_SCALE][3:0]; // RULE22
  assign vsc   = vprod[18:3];                                   // RULE22
  assign ms_tick = (s_r.tick == 16'(CYC_PER_STEP - 1));
  assign start = (~s_r.cfg[rfs_pkg::SL_ONOFF][3]
                  | s_r.cfg[rfs_pkg::SL_OPERATION][7])
               & (~s_r.cfg[rfs_pkg::SL_ONOFF][2] | s_r.en_sync[1]); // RULE21

  // ------------------------------------------------------------
  // fault detection
  // ------------------------------------------------------------
  assign uv_cond  = (s_r.seq == rfs_pkg::ST_ON) && s_r.reached
                  && (vsc < s_r.cfg[rfs_pkg::SL_UV_LIM]);           // RULE1
  assign oc_cond  = iout_code > s_r.cfg[rfs_pkg::SL_OC_LIM];        // RULE3
  assign ot_cond  = temp_code >= s_r.cfg[rfs_pkg::SL_OT_LIM];       // RULE5
  assign otw_cond = temp_code >= s_r.cfg[rfs_pkg::SL_OT_WARN];      // RULE7
  assign vov_cond = vin_code > s_r.cfg[rfs_pkg::SL_VIN_OV_LIM];     // RULE8
  assign vuv_cond = vin_code < s_r.cfg[rfs_pkg::SL_VIN_UV_LIM];     // RULE10
  assign tmo_cond = (s_r.cfg[rfs_pkg::SL_TURN_ON_TIMEOUT][6:0] != 7'h00)
                  && !s_r.reached
                  && (s_r.seq inside {rfs_pkg::ST_RISE, rfs_pkg::ST_ON})
                  && (s_r.ton_ms >= s_r.cfg[rfs_pkg::SL_TURN_ON_TIMEOUT][6:0]); // RULE15

  // overcurrent and input overvoltage stop the stage on any code but ignore; the others on shutdown only
  assign sd_any =
      (uv_cond && s_r.cfg[rfs_pkg::SL_UV_ACT][7:0] == `RFS_ACT_SHUTDOWN) // RULE2
    | (oc_cond && s_r.cfg[rfs_pkg::SL_OC_ACT][7:0] != `RFS_ACT_IGNORE)  // RULE4
    | (ot_cond && s_r.cfg[rfs_pkg::SL_OT_ACT][7:0] == `RFS_ACT_SHUTDOWN) // RULE6
    | (vov_cond
       && s_r.cfg[rfs_pkg::SL_VIN_OV_ACT][7:0] != `RFS_ACT_IGNORE)      // RULE9
    | (tmo_cond
       && s_r.cfg[rfs_pkg::SL_TURN_ON_TIMEOUT_ACT][7:0] == `RFS_ACT_SHUTDOWN);  // RULE16
  // inhibit holds off only while the die stays hot, no latch
  assign inhibit = ot_cond
    && s_r.cfg[rfs_pkg::SL_OT_ACT][7:0] == `RFS_ACT_INHIBIT;            // RULE6

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt           = s_r;
    clr             = 1'b0;
    cml             = 1'b0;
    s_nxt.en_sync   = {s_r.en_sync[0], en_pin};
    s_nxt.rsp_valid = 1'b0;
    s_nxt.tick      = ms_tick ? 16'h0000 : s_r.tick + 16'h0001;
    if (ms_tick && s_r.ms != 7'h7f) begin
      s_nxt.ms = s_r.ms + 7'h01;
    end
    // command port
    if (cmd_valid) begin
      if (cmd_write && cmd_code == `RFS_OFS_CLEAR) begin
        clr = 1'b1;
      end else if (slot == rfs_pkg::SL_NONE) begin
        cml = 1'b1;
      end else if (cmd_write) begin
        if (slot == rfs_pkg::SL_STATUS) begin
          cml = 1'b1;
        end else begin
          s_nxt.cfg[slot] = is_byte(slot) ? {8'h00, cmd_wdata[7:0]}
                                           : cmd_wdata;
        end
      end else begin
        s_nxt.rsp_valid = 1'b1;
        s_nxt.rsp_data  = (slot == rfs_pkg::SL_STATUS)
                        ? {8'h00, s_r.status} : s_r.cfg[slot];
      end
    end
    // sequencer
    unique case (s_r.seq)
      rfs_pkg::ST_OFF: begin
        if (start && !s_r.latch_off && !inhibit) begin
          s_nxt.seq = rfs_pkg::ST_DLY_ON;
        end
      end
      rfs_pkg::ST_DLY_ON: begin
        if (!start) begin
          s_nxt.seq = rfs_pkg::ST_OFF;
        end else if (s_r.ms >= s_r.cfg[rfs_pkg::SL_TON_DLY][6:0]) begin
          s_nxt.seq = rfs_pkg::ST_RISE;                           // RULE13
        end
      end
      rfs_pkg::ST_RISE: begin
        if (!start) begin
          s_nxt.seq = rfs_pkg::ST_DLY_OFF;
        end else if (s_r.ms >= s_r.cfg[rfs_pkg::SL_TURN_ON_RISE_TIME][6:0]) begin
          s_nxt.seq = rfs_pkg::ST_ON;                             // RULE14
        end
      end
      rfs_pkg::ST_ON: begin
        if (!start) begin
          s_nxt.seq = rfs_pkg::ST_DLY_OFF;
        end
      end
      rfs_pkg::ST_DLY_OFF: begin
        if (s_r.ms >= s_r.cfg[rfs_pkg::SL_TOFF_DLY][6:0]) begin
          s_nxt.seq = rfs_pkg::ST_FALL;                           // RULE17
        end
      end
      rfs_pkg::ST_FALL: begin
        if (s_r.ms >= s_r.cfg[rfs_pkg::SL_TURN_OFF_FALL_TIME][6:0]) begin
          s_nxt.seq = rfs_pkg::ST_OFF;                            // RULE18
        end
      end
    endcase
    // fault responses override the sequence in the next cycle
    if (sd_any || inhibit) begin
      s_nxt.seq = rfs_pkg::ST_OFF;                                // RULE23
    end
    if (s_nxt.seq != s_r.seq) begin
      s_nxt.ms   = 7'h00;
      s_nxt.tick = 16'h0000;
    end
    // shutdown stays latched until stop or clear; set wins
    if (sd_any) begin
      s_nxt.latch_off = 1'b1;
    end else if (clr || !start) begin
      s_nxt.latch_off = 1'b0;
    end
    // turn-on timeout tracking
    if (s_r.seq inside {rfs_pkg::ST_RISE, rfs_pkg::ST_ON}) begin
      if (vsc >= s_r.cfg[rfs_pkg::SL_UV_LIM]) begin
        s_nxt.reached = 1'b1;
      end
      if (ms_tick && !s_r.reached && s_r.ton_ms != 7'h7f) begin
        s_nxt.ton_ms = s_r.ton_ms + 7'h01;
      end
    end else begin
      s_nxt.reached = 1'b0;
      s_nxt.ton_ms  = 7'h00;
    end
    // power good hysteresis
    if (s_r.seq inside {rfs_pkg::ST_RISE, rfs_pkg::ST_ON}) begin
      if (vsc >= s_r.cfg[rfs_pkg::SL_PG_ON]) begin
        s_nxt.pgood = 1'b1;                                       // RULE11
      end else if (vsc <= s_r.cfg[rfs_pkg::SL_PG_OFF]) begin
        s_nxt.pgood = 1'b0;                                       // RULE12
      end
    end else begin
      s_nxt.pgood = 1'b0;
    end
    // summary status: sticky bits except the live off bit, a new event beats clear
    s_nxt.status = clr ? 8'h00 : {3'b000, s_r.status[4:0]};
    s_nxt.status[`RFS_STB_OFF] = (s_nxt.seq != rfs_pkg::ST_ON);   // RULE19
    s_nxt.status[`RFS_STB_OC]  = s_nxt.status[`RFS_STB_OC] | oc_cond; // RULE19
    s_nxt.status[`RFS_STB_VIN_UV] =
      s_nxt.status[`RFS_STB_VIN_UV] | vuv_cond;                   // RULE20
    s_nxt.status[`RFS_STB_TEMP] =
      s_nxt.status[`RFS_STB_TEMP] | ot_cond | otw_cond;           // RULE20
    s_nxt.status[`RFS_STB_CML] = s_nxt.status[`RFS_STB_CML] | cml; // RULE20
    s_nxt.status[`RFS_STB_OTHER] = s_nxt.status[`RFS_STB_OTHER]
      | uv_cond | tmo_cond | vov_cond;                            // RULE23
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= rst_val();
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign rsp_valid   = s_r.rsp_valid;
  assign rsp_data    = s_r.rsp_data;
  assign power_good  = s_r.pgood;
  assign status_byte = s_r.status;
  assign ramp_up     = (s_r.seq == rfs_pkg::ST_RISE);
  assign ramp_down   = (s_r.seq == rfs_pkg::ST_FALL);
  assign deliver_on  = s_r.seq inside {rfs_pkg::ST_RISE, rfs_pkg::ST_ON,
                                       rfs_pkg::ST_DLY_OFF, rfs_pkg::ST_FALL};

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence fall_done;
    s_r.seq == rfs_pkg::ST_FALL
    && s_r.ms >= s_r.cfg[rfs_pkg::SL_TURN_OFF_FALL_TIME][6:0];
  endsequence
  sequence dly_done;
    s_r.seq == rfs_pkg::ST_DLY_ON && start
    && s_r.ms >= s_r.cfg[rfs_pkg::SL_TON_DLY][6:0];
  endsequence

  a_uv_shut_off: assert property ( // RULE2
    uv_cond && s_r.cfg[rfs_pkg::SL_UV_ACT][7:0] == `RFS_ACT_SHUTDOWN
    |=> s_r.seq == rfs_pkg::ST_OFF && s_r.latch_off)
    else $error("undervoltage shutdown not taken");
  a_oc_flag_set: assert property ( // RULE3
    oc_cond |=> status_byte[`RFS_STB_OC])
    else $error("overcurrent not flagged");
  a_oc_stage_stop: assert property ( // RULE4
    oc_cond && s_r.cfg[rfs_pkg::SL_OC_ACT][7:0] != `RFS_ACT_IGNORE
    |=> !deliver_on [*2])
    else $error("overcurrent response not applied");
  a_ot_temp_flag: assert property ( // RULE5
    ot_cond |=> status_byte[`RFS_STB_TEMP])
    else $error("overtemperature not flagged");
  a_ot_inhibit_hold: assert property ( // RULE6
    inhibit && s_r.seq == rfs_pkg::ST_OFF |=> s_r.seq == rfs_pkg::ST_OFF)
    else $error("start while inhibited");
  a_vin_ov_flag: assert property ( // RULE8
    vov_cond |=> status_byte[`RFS_STB_OTHER])
    else $error("input overvoltage not flagged");
  a_vin_uv_flag: assert property ( // RULE10
    vuv_cond |=> status_byte[`RFS_STB_VIN_UV])
    else $error("input undervoltage not flagged");
  a_pg_assert_on: assert property ( // RULE11
    s_r.seq == rfs_pkg::ST_ON && vsc >= s_r.cfg[rfs_pkg::SL_PG_ON]
    |=> power_good)
    else $error("power good not asserted");
  a_pg_negate_off: assert property ( // RULE12
    vsc <= s_r.cfg[rfs_pkg::SL_PG_OFF] && vsc < s_r.cfg[rfs_pkg::SL_PG_ON]
    |=> !power_good)
    else $error("power good not negated");
  a_turn_on_delay_time_end: assert property ( // RULE13
    dly_done and (!sd_any && !inhibit) |=> ramp_up)
    else $error("rise not started after delay");
  a_fall_to_off: assert property ( // RULE18
    fall_done |=> s_r.seq == rfs_pkg::ST_OFF && !deliver_on)
    else $error("fall did not end in off");
  a_off_bit_live: assert property ( // RULE19
    $fell(s_r.seq == rfs_pkg::ST_ON) |-> status_byte[`RFS_STB_OFF])
    else $error("off bit not set on leaving regulation");

endmodule : rfs_regs
`default_nettype wire

/* test/rfs_host.sv */
// host controller model driving the decoded command port
`timescale 1ns/1ps
`default_nettype none
module rfs_host (
  // clock
  input  wire logic        clk,
  // command port
  output var  logic        cmd_valid,
  output var  logic        cmd_write,
  output var  logic [7:0]  cmd_code,
  output var  logic [15:0] cmd_wdata,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // one whole command of the register's full width per call
  task automatic xfer(input logic wr, input logic [7:0] code,
                      input logic [15:0] wd);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_code  <= code;
    cmd_wdata <= wd;
    @(posedge clk);
    cmd_valid <= 1'b0;
    // released lines flip so stale values never look valid
    cmd_code  <= ~code;
    cmd_wdata <= ~wd;
  endtask : xfer
  task automatic rd(input logic [7:0] code, output logic [15:0] d,
                    output logic ok);
    xfer(1'b0, code, 16'h0000);
    @(posedge clk);
    ok = rsp_valid;
    d  = rsp_data;
  endtask : rd
endmodule : rfs_host
`default_nettype wire

/* test/rfs_regs_tb.sv */
// self-checking bench of the fault and sequencing register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module rfs_regs_tb;
  logic clk = 1'b0, arst_n = 1'b0, en_pin = 1'b0;
  logic cmd_valid, cmd_write, rsp_valid, ok;
  logic deliver_on, ramp_up, ramp_down, power_good;
  logic [7:0]  cmd_code, status_byte;
  logic [15:0] cmd_wdata, rsp_data, d;
  logic [15:0] vout = 16'h0000, iout = 16'h0000;
  logic [15:0] temp = 16'h0019, vin = 16'h0030;
  int n_fail = 0, checked = 0, cyc = 0, n;
  // reset image, codes then values in each register's step
  logic [7:0]  rc [20] = '{8'h44, 8'h45, 8'h46, 8'h47, 8'h4a, 8'h4f,
    8'h50, 8'h51, 8'h55, 8'h56, 8'h58, 8'h5e, 8'h5f, 8'h60, 8'h61,
    8'h62, 8'h63, 8'h64, 8'h65, 8'h29};
  logic [15:0] rv [20] = '{16'h0065, 16'h0000, 16'h0012, 16'h0080,
    16'h000f, 16'h0091, 16'h00c0, 16'h007d, 16'h0060, 16'h0080, 16'h0001,
    16'h002d, 16'h002a, 16'h0000, 16'h0002, 16'h0000, 16'h0000, 16'h0000,
    16'h0001, 16'h0008};

  always #20 clk = ~clk;
  // short step keeps millisecond timers within a few tens of cycles
  rfs_regs #(.CYC_PER_STEP(10)) i_dut (
    .clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .en_pin(en_pin),
    .vout_code(vout), .iout_code(iout), .temp_code(temp), .vin_code(vin),
    .deliver_on(deliver_on), .ramp_up(ramp_up), .ramp_down(ramp_down),
    .power_good(power_good), .status_byte(status_byte));
  rfs_host i_host (
    .clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data));

  task automatic finish_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  task automatic rdchk(input logic [7:0] code, input logic [15:0] e);
    i_host.rd(code, d, ok);
    `CHK("rsp_valid", 1'b1, ok)
    `CHK("rsp_data", e, d)
  endtask : rdchk

  // ceiling well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      finish_test();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      rdchk(rc[i], rv[i]);
    end
    rdchk(8'h78, 16'h0040);
    i_host.xfer(1'b1, 8'h45, 16'hff80);
    rdchk(8'h45, 16'h0080);
    i_host.xfer(1'b1, 8'h45, 16'h0000);
    i_host.xfer(1'b1, 8'h60, 16'h0002);
    rdchk(8'h60, 16'h0002);
    i_host.xfer(1'b1, 8'h64, 16'h0001);
    // start: delay, then rise
    @(posedge clk);
    en_pin <= 1'b1;
    for (n = 0; n < 80 && ramp_up !== 1'b1; n++) @(posedge clk);
    `CHK("turn-on delay", 1'b1, n >= 20 && n <= 45)
    `CHK("deliver_on", 1'b1, deliver_on)
    vout <= 16'h0070;
    for (n = 0; n < 80 && ramp_up !== 1'b0; n++) @(posedge clk);
    `CHK("rise time", 1'b1, n >= 18 && n <= 35)
    repeat (3) @(posedge clk);
    `CHK("power_good on", 1'b1, power_good)
    rdchk(8'h78, 16'h0000);
    // output sags: good drops, ignored fault keeps running
    vout <= 16'h0028;
    repeat (4) @(posedge clk);
    `CHK("power_good off", 1'b0, power_good)
    rdchk(8'h78, 16'h0001);
    `CHK("deliver_on", 1'b1, deliver_on)
    // stop: energy kept for the delay, then fall
    en_pin <= 1'b0;
    for (n = 0; n < 80 && ramp_down !== 1'b1; n++) @(posedge clk);
    `CHK("turn-off delay", 1'b1, n >= 10 && n <= 30)
    `CHK("deliver_on", 1'b1, deliver_on)
    for (n = 0; n < 80 && deliver_on !== 1'b0; n++) @(posedge clk);
    `CHK("fall time", 1'b1, n >= 8 && n <= 25)
    i_host.xfer(1'b1, 8'h03, 16'h0000);
    // fault flags while off
    iout <= 16'h0013;
    temp <= 16'h007d;
    vin  <= 16'h0061;
    rdchk(8'h78, 16'h0055);
    vin  <= 16'h0000;
    rdchk(8'h78, 16'h005d);
    i_host.xfer(1'b1, 8'h78, 16'h00ff);
    rdchk(8'h78, 16'h005f);
    i_host.rd(8'h99, d, ok);
    `CHK("unmapped rsp_valid", 1'b0, ok)
    iout <= 16'h0000;
    temp <= 16'h0019;
    vin  <= 16'h0030;
    i_host.xfer(1'b1, 8'h03, 16'h0000);
    rdchk(8'h78, 16'h0040);
    // half scale keeps the output short of the limit, so rise times out
    vout <= 16'h00c8;
    temp <= 16'h0091;
    i_host.xfer(1'b1, 8'h29, 16'h0004);
    i_host.xfer(1'b1, 8'h62, 16'h0001);
    i_host.xfer(1'b1, 8'h63, 16'h0080);
    i_host.xfer(1'b1, 8'h01, 16'h0080);
    i_host.xfer(1'b1, 8'h02, 16'h0008);
    repeat (30) @(posedge clk);
    `CHK("inhibit deliver_on", 1'b0, deliver_on)
    temp <= 16'h0019;
    for (n = 0; n < 80 && deliver_on !== 1'b1; n++) @(posedge clk);
    `CHK("restart deliver_on", 1'b1, deliver_on)
    repeat (40) @(posedge clk);
    `CHK("timeout deliver_on", 1'b0, deliver_on)
    rdchk(8'h78, 16'h0045);
    `CHK("status_byte", 8'h45, status_byte)
    finish_test();
  end
endmodule : rfs_regs_tb
`default_nettype wire
